// ==== logic/gated_timer.v ====
// 16-bit timer/counter with prescaler, gate accumulation and match interrupt
// Assumes an AHB-Lite master on i_mclk and an asynchronous count and gate pin
//
// The register offsets and the AHB-Lite register port were decided locally.
`timescale 1ns/1ps
`include "gated_timer_consts.vh"

module gated_timer #(
	parameter WIDTH = 16
) (
	// Clock and reset
	input wire i_mclk,
	input wire i_reset,
	// AHB-Lite slave
	input wire i_hsel,
	input wire [31:0] i_haddr,
	input wire [1:0] i_htrans,
	input wire i_hwrite,
	input wire [2:0] i_hsize,
	input wire [31:0] i_hwdata,
	input wire i_hready,
	output wire [31:0] o_hrdata,
	output wire o_hreadyout,
	output wire o_hresp,
	// Pins and device state
	input wire i_external_count_pin,
	input wire i_gate_pin,
	input wire i_device_idle,
	// Interrupt
	output wire o_irq
);

	// ==================================================
	// Pin synchronisers
	reg [2:0] cnt_sync_reg;
	reg [2:0] gate_sync_reg;
	reg cnt_state_reg;
	reg gate_state_reg;
	reg raw_prev_reg;
	wire cnt_rise;
	wire gate_fall;

	always @(posedge i_mclk) begin
		if (i_reset) begin
			cnt_sync_reg <= 3'h0;
			gate_sync_reg <= 3'h0;
			cnt_state_reg <= 1'b0;
			gate_state_reg <= 1'b0;
			raw_prev_reg <= 1'b0;
		end else begin
			cnt_sync_reg <= {cnt_sync_reg[1:0], i_external_count_pin};
			gate_sync_reg <= {gate_sync_reg[1:0], i_gate_pin};
			raw_prev_reg <= cnt_sync_reg[2];
			if (cnt_sync_reg[1] == cnt_sync_reg[2])
				cnt_state_reg <= cnt_sync_reg[2];
			if (gate_sync_reg[1] == gate_sync_reg[2])
				gate_state_reg <= gate_sync_reg[2];
		end
	end

	// ==================================================
	// Registers
	reg [15:0] control_reg;
	reg [WIDTH-1:0] count_reg;
	reg [WIDTH-1:0] period_reg;
	reg [1:0] status_reg;
	reg [1:0] mask_reg;
	reg gate_prev_reg;
	reg cnt_prev_reg;

	wire run = control_reg[`BIT_RUN];
	wire idle_halt = control_reg[`BIT_IDLE_HALT];
	wire clock_source_select = control_reg[`BIT_CLKSRC];
	wire external_input_resync = control_reg[`BIT_RESYNC];
	wire [1:0] prescale_select = control_reg[`BIT_PS_HI:`BIT_PS_LO];
	// Gate ignored with external source
	wire gate_mode = control_reg[`BIT_GATE] & ~clock_source_select;
	// Idle stops only when halt bit set
	wire active = run & ~(idle_halt & i_device_idle);

	// Unsynced path uses the raw last sync stage; resynced path the filtered level
	wire ext_rise = external_input_resync ? (cnt_state_reg & ~cnt_prev_reg) :
		(cnt_sync_reg[2] & ~raw_prev_reg);
	wire gate_ok = ~gate_mode | gate_state_reg;
	wire tick_src = clock_source_select ? ext_rise : 1'b1;
	assign gate_fall = gate_mode & gate_prev_reg & ~gate_state_reg;

	// ==================================================
	// Prescaler
	reg [7:0] ps_reg;
	reg [7:0] ps_tc;
	always @* begin
		case (prescale_select)
			`PS_DIV1: ps_tc = 8'h00;
			`PS_DIV8: ps_tc = `PS_TC8;
			`PS_DIV64: ps_tc = `PS_TC64;
			default: ps_tc = `PS_TC256;
		endcase
	end
	wire ps_in = active & tick_src & gate_ok;
	wire inc = ps_in & (ps_reg >= ps_tc);
	wire match = inc & (count_reg == period_reg);

	// ==================================================
	// Bus slave
	reg wr_pend_reg;
	reg [`ADDR_BITS-1:0] addr_reg;
	reg [31:0] rdata_reg;
	wire take = i_hsel & i_hready & i_htrans[`HTRANS_NONSEQ_BIT];
	wire wr_ctl = wr_pend_reg & (addr_reg == `ADDR_CONTROL);
	wire wr_cnt = wr_pend_reg & (addr_reg == `ADDR_COUNT);
	wire wr_per = wr_pend_reg & (addr_reg == `ADDR_PERIOD);
	wire wr_st = wr_pend_reg & (addr_reg == `ADDR_STATUS);
	wire wr_msk = wr_pend_reg & (addr_reg == `ADDR_MASK);
	reg [31:0] rd_mux;

	always @* begin
		case (i_haddr[`ADDR_BITS-1:0])
			`ADDR_CONTROL: rd_mux = {16'h0000, control_reg & `CONTROL_MASK};
			`ADDR_COUNT: rd_mux = {{(32-WIDTH){1'b0}}, count_reg};
			`ADDR_PERIOD: rd_mux = {{(32-WIDTH){1'b0}}, period_reg};
			`ADDR_STATUS: rd_mux = {30'h0, status_reg};
			`ADDR_MASK: rd_mux = {30'h0, mask_reg};
			default: rd_mux = 32'h0;
		endcase
	end

	always @(posedge i_mclk) begin
		if (i_reset) begin
			wr_pend_reg <= 1'b0;
			addr_reg <= {`ADDR_BITS{1'b0}};
			rdata_reg <= 32'h0;
		end else begin
			wr_pend_reg <= take & i_hwrite;
			if (take)
				addr_reg <= i_haddr[`ADDR_BITS-1:0];
			if (take & ~i_hwrite)
				rdata_reg <= rd_mux;
		end
	end

	assign o_hrdata = rdata_reg;
	assign o_hreadyout = 1'b1;
	assign o_hresp = `HRESP_OKAY;

	// ==================================================
	// Timer core
	always @(posedge i_mclk) begin
		if (i_reset) begin
			control_reg <= `CONTROL_RESET;
			count_reg <= {WIDTH{1'b0}};
			period_reg <= `PERIOD_RESET;
			status_reg <= 2'h0;
			mask_reg <= 2'h0;
			ps_reg <= 8'h00;
			gate_prev_reg <= 1'b0;
			cnt_prev_reg <= 1'b0;
		end else begin
			gate_prev_reg <= gate_state_reg;
			cnt_prev_reg <= cnt_state_reg;
			if (wr_ctl)
				control_reg <= i_hwdata[15:0] & `CONTROL_MASK;
			if (wr_per)
				period_reg <= i_hwdata[WIDTH-1:0];
			if (wr_msk)
				mask_reg <= i_hwdata[1:0];
			if (ps_in)
				ps_reg <= inc ? 8'h00 : ps_reg + 8'h01;
			if (wr_cnt) begin
				count_reg <= i_hwdata[WIDTH-1:0];
				ps_reg <= 8'h00;
			end else if (match)
				count_reg <= {WIDTH{1'b0}};
			else if (inc)
				count_reg <= count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
			// Set wins over write-one clear
			status_reg <= (status_reg & ~(wr_st ? i_hwdata[1:0] : 2'h0)) |
				{gate_fall, match};
		end
	end

	assign o_irq = |(status_reg & mask_reg);

endmodule

// ==== logic/gated_timer_consts.vh ====
// Constants of the 16-bit gated timer: register map, control fields, prescale
// Assumes inclusion by bare name from the timer module
`ifndef GATED_TIMER_CONSTS_VH
`define GATED_TIMER_CONSTS_VH

// ==================================================
// Register byte addresses
`define ADDR_CONTROL 5'h00
`define ADDR_COUNT 5'h04
`define ADDR_PERIOD 5'h08
`define ADDR_STATUS 5'h0c
`define ADDR_MASK 5'h10
`define ADDR_BITS 5

// ==================================================
// Control fields
`define BIT_RUN 15
`define BIT_IDLE_HALT 13
`define BIT_GATE 6
`define BIT_PS_HI 5
`define BIT_PS_LO 4
`define BIT_RESYNC 2
`define BIT_CLKSRC 1
`define CONTROL_MASK 16'ha076
`define CONTROL_RESET 16'h0000
`define PERIOD_RESET 16'hffff

// ==================================================
// Status bits
`define ST_MATCH 0
`define ST_GATE_FALL 1

// ==================================================
// Prescale terminal counts
`define PS_DIV1 2'h0
`define PS_DIV8 2'h1
`define PS_DIV64 2'h2
`define PS_TC8 8'h07
`define PS_TC64 8'h3f
`define PS_TC256 8'hff

// AHB-Lite
`define HTRANS_NONSEQ_BIT 1
`define HRESP_OKAY 1'b0

`endif

// ==== verification/gated_timer_properties.sv ====
// Port checker for the gated timer: bus answers, read data and interrupt
// Assumes binding to gated_timer and a single AHB-Lite master
`timescale 1ns/1ps
module gated_timer_chk (
	// Clock and reset
	input wire i_mclk,
	input wire i_reset,
	// Bus
	input wire i_hsel,
	input wire [31:0] i_haddr,
	input wire [1:0] i_htrans,
	input wire i_hwrite,
	input wire [31:0] i_hwdata,
	input wire i_hready,
	input wire [31:0] o_hrdata,
	input wire o_hreadyout,
	input wire o_hresp,
	// Interrupt
	input wire o_irq
);
	wire take = i_hsel & i_hready & i_htrans[1];
	wire rd = take & ~i_hwrite;
	wire rd_ctl = rd & (i_haddr[4:0] == 5'h00);
	wire rd_st = rd & (i_haddr[4:0] == 5'h0c);
	reg wr_q;
	reg mwr_q;
	always @(posedge i_mclk) begin
		wr_q <= take & i_hwrite;
		mwr_q <= take & i_hwrite & (i_haddr[4:0] == 5'h10);
	end
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_reset);
	// ====================
	// Assertions
	chk_ready_high: assert property (o_hreadyout)
		else $error("hreadyout low");
	chk_resp_okay: assert property (!o_hresp)
		else $error("hresp not okay");
	chk_rdata_hold: assert property ($changed(o_hrdata) |-> $past(rd))
		else $error("hrdata moved without read");
	chk_upper_zero: assert property ($past(rd) |-> o_hrdata[31:16] == 16'h0000)
		else $error("upper read bits set");
	chk_ctl_unimpl: assert property ($past(rd_ctl) |-> (o_hrdata & ~32'ha076) == 32'h0)
		else $error("unimplemented control bit set");
	chk_status_bits: assert property ($past(rd_st) |-> o_hrdata[31:2] == 30'h0)
		else $error("status bit out of range");
	chk_irq_fall: assert property ($fell(o_irq) |-> $past(wr_q))
		else $error("irq fell without write");
	chk_mask_off: assert property (mwr_q && i_hwdata == 32'h0 |=> !o_irq)
		else $error("irq with mask cleared");
	cov_irq_rise: cover property ($rose(o_irq));
	cov_ctl_read: cover property (rd_ctl);
	cov_mask_clear: cover property (mwr_q && i_hwdata == 32'h0);
endmodule

bind gated_timer gated_timer_chk gated_timer_chk_i (.i_mclk(i_mclk), .i_reset(i_reset),
	.i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
	.i_hwdata(i_hwdata), .i_hready(i_hready), .o_hrdata(o_hrdata),
	.o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_irq(o_irq));

// ==== verification/gated_timer_tb.sv ====
// Bench for the gated timer: bus tasks and one task per scenario
// Assumes zero wait states and no other bus master
`timescale 1ns/1ps
module gated_timer_tb;
	reg clk = 1'b0, rst = 1'b1, wrt = 1'b0, pin = 1'b0, gate = 1'b0, idle = 1'b0;
	reg [1:0] trans = 2'h0;
	reg [31:0] addr = 32'h0, wdat = 32'h0, r;
	wire [31:0] rdat;
	wire rdy, irq;
	integer error_cnt = 0, cmp_count = 0, cyc = 0;
	gated_timer gated_timer_i (.i_mclk(clk), .i_reset(rst), .i_hsel(1'b1), .i_haddr(addr),
		.i_htrans(trans), .i_hwrite(wrt), .i_hsize(3'h2), .i_hwdata(wdat), .i_hready(rdy),
		.o_hrdata(rdat), .o_hreadyout(rdy), .o_hresp(), .i_external_count_pin(pin),
		.i_gate_pin(gate), .i_device_idle(idle), .o_irq(irq));
	initial forever #5 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			error_cnt = error_cnt + 1;
			wrap_up;
		end
	end
	task wrap_up;
		$display("compares %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task cmp(input [31:0] got, input [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task tick(input integer n);
		repeat (n) @(posedge clk);
	endtask
	// ====================
	// Bus cycles
	task xfer(input w, input [4:0] a, input [31:0] d);
		trans <= 2'h2;
		wrt <= w;
		addr <= {27'h0, a};
		do @(posedge clk); while (!rdy);
		trans <= 2'h0;
		wdat <= d;
		do @(posedge clk); while (!rdy);
		r = rdat;
	endtask
	task wr(input [4:0] a, input [31:0] d);
		xfer(1'b1, a, d);
	endtask
	task rdc(input [4:0] a, input [31:0] e);
		xfer(1'b0, a, 32'h0);
		cmp(r, e);
	endtask
	// ====================
	// Scenarios
	task t_reset;
		rdc(5'h00, 32'h0);
		rdc(5'h08, 32'hffff);
		rdc(5'h0c, 32'h0);
		rdc(5'h10, 32'h0);
		rdc(5'h14, 32'h0);
		wr(5'h00, 32'hffffffff);
		rdc(5'h00, 32'ha076);
	endtask
	task t_prescale;
		for (int p = 1; p < 4; p++) begin
			wr(5'h00, 32'h0);
			wr(5'h04, 32'h0);
			wr(5'h00, 32'h8000 | (p << 4));
			tick((p == 3 ? 256 : 1 << (3 * p)) * 9 / 2);
			wr(5'h00, 32'h0);
			rdc(5'h04, 32'h4);
		end
	endtask
	task t_match;
		wr(5'h10, 32'h1);
		wr(5'h08, 32'h3);
		wr(5'h04, 32'h0);
		wr(5'h00, 32'h8000);
		tick(9);
		wr(5'h00, 32'h0);
		cmp(irq, 1'b1);
		rdc(5'h0c, 32'h1);
		xfer(1'b0, 5'h04, 32'h0);
		cmp(r < 4, 1'b1);
		tick(20);
		rdc(5'h04, r);
		wr(5'h0c, 32'h1);
		rdc(5'h0c, 32'h0);
		cmp(irq, 1'b0);
	endtask
	task t_idle;
		idle <= 1'b1;
		wr(5'h08, 32'hffff);
		wr(5'h04, 32'h0);
		wr(5'h00, 32'ha000);
		tick(20);
		rdc(5'h04, 32'h0);
		wr(5'h00, 32'h8000);
		tick(20);
		wr(5'h00, 32'h0);
		xfer(1'b0, 5'h04, 32'h0);
		cmp(r > 20, 1'b1);
		idle <= 1'b0;
	endtask
	task t_gate;
		wr(5'h10, 32'h2);
		wr(5'h04, 32'h0);
		wr(5'h00, 32'h8040);
		tick(20);
		rdc(5'h04, 32'h0);
		gate <= 1'b1;
		tick(30);
		gate <= 1'b0;
		tick(10);
		cmp(irq, 1'b1);
		wr(5'h00, 32'h0);
		rdc(5'h0c, 32'h2);
		xfer(1'b0, 5'h04, 32'h0);
		cmp(r > 20 && r < 40, 1'b1);
		wr(5'h0c, 32'h3);
		wr(5'h10, 32'h0);
	endtask
	task t_ext;
		for (int s = 0; s < 2; s++) begin
			wr(5'h04, 32'h0);
			wr(5'h00, 32'h8042 | (s << 2));
			repeat (5) begin
				pin <= 1'b1;
				tick(6);
				pin <= 1'b0;
				tick(6);
			end
			wr(5'h00, 32'h0);
			rdc(5'h04, 32'h5);
		end
	endtask
	initial begin
		tick(2);
		rst <= 1'b0;
		t_reset;
		t_prescale;
		t_match;
		t_idle;
		t_gate;
		t_ext;
		wrap_up;
	end
endmodule
